// >>> rtl/cx_exec.sv
// cx_exec: execution datapath for a subset of a 16-bit DSP core
// assumes one AHB-Lite master doing single word transfers, one clock
//
// Function
// - rotate right by one without carry, flags N and Z only
// - store accumulator shifted by signed 4-bit literal, optionally rounded, no flags
// - sign extend low byte of source, update C, N and Z
// - arithmetic accumulator shift by register or signed 6-bit literal, range flags
// - shift left by one, update C, N, overflow and Z
// - shift left by register or 5-bit count, update N and Z only
// - subtract accumulators in one cycle, update range and clip flags
// - subtract with register, 10-bit or 5-bit literal, update five flags
// - subtract with borrow: also subtract inverted carry, update five flags
// - reversed subtract, update C, nibble carry, N, overflow and Z
// - reversed subtract with borrow, update five flags
// - nibble swap and byte swap in one cycle, no flags
// - table read high: program bits 23..16 to low byte, two cycles
// - table read low: program bits 15..0 to destination, two cycles
// - table write high: source low byte to program bits 23..16
// - table write low: source word to program bits 15..0, two cycles
// - frame unlink in one word and one cycle, no flags changed
// - exclusive-or with register or literals, update N and Z only
//
// Our own choices: the register offsets and the AHB-Lite register port.
`default_nettype none

module cx_exec #(
	parameter int PROG_AW = 8,  // program memory address bits
	parameter int STK_AW  = 6   // stack memory word address bits
) (
	input  wire logic                     hclk,       // clock
	input  wire logic                     hresetn,    // async reset, active low
	input  wire logic                     hsel,       // slave select
	input  wire logic [cx_pkg::BUS_W-1:0] haddr,      // byte address
	input  wire logic [1:0]               htrans,     // transfer type
	input  wire logic                     hwrite,     // write when high
	input  wire logic [2:0]               hsize,      // word only
	input  wire logic [cx_pkg::BUS_W-1:0] hwdata,     // write data
	input  wire logic                     hready,     // bus ready
	output logic      [cx_pkg::BUS_W-1:0] hrdata,     // read data
	output logic                          hreadyout,  // slave ready
	output logic                          hresp       // always OKAY
);
	import cx_pkg::*;

	// ****************************************
	// functions
	// ****************************************
	// positive amount shifts right arithmetically, negative shifts left
	function automatic logic [ACC_W-1:0] acc_shift(input logic [ACC_W-1:0] v,
		input logic signed [6:0] s);
		logic [ACC_W-1:0] r;
		r = v;
		if (s[6]) begin
			r = v << 7'(-s);
		end else begin
			r = ACC_W'($signed(v) >>> s);
		end
		return r;
	endfunction

	function automatic logic acc_range(input logic [ACC_W-1:0] v);
		return !((&v[ACC_W-1:GUARD_LSB]) || !(|v[ACC_W-1:GUARD_LSB]));
	endfunction

	function automatic logic [15:0] set_nz(input logic [15:0] f, input logic [15:0] r);
		logic [15:0] o;
		o = f;
		o[F_NEG] = r[15];
		o[F_ZERO] = (r == 16'h0000);
		return o;
	endfunction

	// range flags follow both accumulators, clip flags are sticky
	function automatic logic [15:0] acc_flags(input logic [15:0] f,
		input logic [ACC_W-1:0] a, input logic [ACC_W-1:0] b,
		input logic sel_b, input logic clip);
		logic [15:0] o;
		o = f;
		o[F_ACCA_RNG] = acc_range(a);
		o[F_ACCB_RNG] = acc_range(b);
		o[F_EITHER_RNG] = o[F_ACCA_RNG] | o[F_ACCB_RNG];
		if (clip && sel_b) begin
			o[F_ACCB_CLIP] = 1'b1;
		end else if (clip) begin
			o[F_ACCA_CLIP] = 1'b1;
		end
		o[F_EITHER_CLIP] = o[F_ACCA_CLIP] | o[F_ACCB_CLIP];
		return o;
	endfunction

	// ****************************************
	// bus slave
	// ****************************************
	logic              acc_ok;
	logic              wr_pend_reg;
	logic              rd_pend_reg;
	logic [BUS_W-1:0]  da_reg;
	logic              hreadyout_reg;
	logic              hresp_reg;
	logic [BUS_W-1:0]  hrdata_reg;
	logic [BUS_W-1:0]  rd_next;
	logic              wen;

	assign acc_ok = hsel & htrans[1] & hready;
	assign wen = wr_pend_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			da_reg <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= acc_ok & hwrite;
			rd_pend_reg <= acc_ok & ~hwrite;
			if (acc_ok) begin
				da_reg <= haddr;
			end
		end
	end

	// reads take one wait state so hrdata comes from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_reg <= 1'b1;
			hresp_reg <= 1'b0;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			hreadyout_reg <= ~(acc_ok & ~hwrite);
			hresp_reg <= 1'b0;
			if (rd_pend_reg) begin
				hrdata_reg <= rd_next;
			end
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = hresp_reg;

	// ****************************************
	// state and operands
	// ****************************************
	cx_state_e          state_reg;
	logic [1:0]         tcnt_reg;
	logic [BUS_W-1:0]   cmd_reg;
	logic [DATA_W-1:0]  opa_reg;
	logic [DATA_W-1:0]  opb_reg;
	logic [DATA_W-1:0]  res_reg;
	logic [DATA_W-1:0]  flags_reg;
	logic [DATA_W-1:0]  sp_reg;
	logic [DATA_W-1:0]  fp_reg;
	logic [DATA_W-1:0]  pc_reg;
	logic [ACC_W-1:0]   acca_reg;
	logic [ACC_W-1:0]   accb_reg;
	logic               cmd_go;
	logic               tbl_done;
	logic               push;
	cx_op_e             op;
	cx_op_e             op_t;
	logic [9:0]         lit;
	logic [1:0]         src;
	logic               acc_b;
	logic [DATA_W-1:0]  opnd_b;
	logic [DATA_W-1:0]  fp_m2;
	logic [PROG_W-1:0]  prog_rd;
	logic [DATA_W-1:0]  stk_rd;
	logic               pwe;
	logic [PROG_W-1:0]  pmask;

	assign cmd_go = wen && (da_reg == A_CMD) && (state_reg == ST_IDLE);
	assign op = cx_op_e'(hwdata[CMD_OP_LSB +: 5]);
	assign op_t = cx_op_e'(cmd_reg[CMD_OP_LSB +: 5]);
	assign lit = hwdata[CMD_LIT_LSB +: 10];
	assign src = hwdata[CMD_SRC_LSB +: 2];
	assign acc_b = hwdata[CMD_ACC_BIT];
	assign tbl_done = (state_reg == ST_TABLE) && (tcnt_reg == TBL_LAST);
	assign push = wen && (da_reg == A_PUSH);
	assign fp_m2 = fp_reg - STK_STEP;

	always_comb begin
		if (src == SRC_LIT5) begin
			opnd_b = {11'h000, lit[4:0]};
		end else if (src == SRC_LIT10) begin
			opnd_b = {6'h00, lit};
		end else begin
			opnd_b = opb_reg;
		end
	end

	// ****************************************
	// subtract family
	// ****************************************
	logic               rev;
	logic               borrow;
	logic [DATA_W-1:0]  sub_x;
	logic [DATA_W-1:0]  sub_y;
	logic [DATA_W-1:0]  sub_d;
	logic               sub_c;
	logic               sub_dc;
	logic               sub_ov;

	assign rev = (op == op_sub_rev) || (op == op_sub_rev_borrow);
	assign borrow = (op == op_sub_borrow) || (op == op_sub_rev_borrow);
	assign sub_x = rev ? opnd_b : opa_reg;
	assign sub_y = rev ? opa_reg : opnd_b;

	cx_sub #(.W(DATA_W)) u_sub (
		.x  (sub_x),
		.y  (sub_y),
		.ci (borrow ? flags_reg[F_CARRY] : 1'b1),
		.d  (sub_d),
		.c  (sub_c),
		.dc (sub_dc),
		.ov (sub_ov)
	);

	// ****************************************
	// one-cycle results
	// ****************************************
	logic [DATA_W-1:0]  res_n;
	logic [DATA_W-1:0]  flags_n;
	logic [ACC_W-1:0]   acca_n;
	logic [ACC_W-1:0]   accb_n;
	logic [ACC_W-1:0]   acc_src;
	logic [ACC_W-1:0]   acc_sh;
	logic [ACC_W-1:0]   acc_dif;
	logic signed [6:0]  shamt;
	logic               clip;

	assign acc_src = acc_b ? accb_reg : acca_reg;

	always_comb begin
		res_n = res_reg;
		flags_n = flags_reg;
		acca_n = acca_reg;
		accb_n = accb_reg;
		shamt = 7'sh00;
		acc_sh = acc_src;
		acc_dif = acc_src;
		clip = 1'b0;
		case (op)
			op_rotate_right_nc: begin
				res_n = {opa_reg[0], opa_reg[15:1]};
				flags_n = set_nz(flags_reg, res_n);
			end
			op_store_acc, op_store_acc_rnd: begin
				shamt = {{3{lit[3]}}, lit[3:0]};
				acc_sh = acc_shift(acc_src, shamt);
				if (op == op_store_acc_rnd) begin
					acc_sh = acc_sh + RND_BIAS;
				end
				res_n = acc_sh[HW_LSB +: DATA_W];
			end
			op_sign_extend: begin
				res_n = {{8{opa_reg[7]}}, opa_reg[7:0]};
				flags_n = set_nz(flags_reg, res_n);
				flags_n[F_CARRY] = ~res_n[15];
			end
			op_set_all_ones: begin
				res_n = ALL_ONES;
			end
			op_acc_shift: begin
				if (src == SRC_REG) begin
					shamt = {opb_reg[5], opb_reg[5:0]};
				end else begin
					shamt = {lit[5], lit[5:0]};
				end
				acc_sh = acc_shift(acc_src, shamt);
				clip = shamt[6] && (acc_shift(acc_sh, -shamt) != acc_src);
				if (acc_b) begin
					accb_n = acc_sh;
				end else begin
					acca_n = acc_sh;
				end
				flags_n = acc_flags(flags_reg, acca_n, accb_n, acc_b, clip);
			end
			op_left_shift1: begin
				res_n = {opa_reg[14:0], 1'b0};
				flags_n = set_nz(flags_reg, res_n);
				flags_n[F_CARRY] = opa_reg[15];
				flags_n[F_RANGE] = opa_reg[15] ^ opa_reg[14];
			end
			op_left_shift_n: begin
				if (src == SRC_REG) begin
					res_n = opa_reg << opb_reg[4:0];
				end else begin
					res_n = opa_reg << lit[4:0];
				end
				flags_n = set_nz(flags_reg, res_n);
			end
			op_sub_acc: begin
				if (acc_b) begin
					acc_dif = accb_reg - acca_reg;
					accb_n = acc_dif;
					clip = (accb_reg[ACC_W-1] != acca_reg[ACC_W-1])
						&& (acc_dif[ACC_W-1] != accb_reg[ACC_W-1]);
				end else begin
					acc_dif = acca_reg - accb_reg;
					acca_n = acc_dif;
					clip = (acca_reg[ACC_W-1] != accb_reg[ACC_W-1])
						&& (acc_dif[ACC_W-1] != acca_reg[ACC_W-1]);
				end
				flags_n = acc_flags(flags_reg, acca_n, accb_n, acc_b, clip);
			end
			op_sub, op_sub_borrow, op_sub_rev, op_sub_rev_borrow: begin
				res_n = sub_d;
				flags_n = set_nz(flags_reg, res_n);
				flags_n[F_CARRY] = sub_c;
				flags_n[F_NIBBLE] = sub_dc;
				flags_n[F_RANGE] = sub_ov;
			end
			op_nibble_exch: begin
				res_n = {opa_reg[15:8], opa_reg[3:0], opa_reg[7:4]};
			end
			op_byte_exch: begin
				res_n = {opa_reg[7:0], opa_reg[15:8]};
			end
			op_xor: begin
				res_n = opa_reg ^ opnd_b;
				flags_n = set_nz(flags_reg, res_n);
			end
			default: begin
			end
		endcase
	end

	// ****************************************
	// sequencing and program counter
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			tcnt_reg <= 2'h0;
			cmd_reg <= 32'h0000_0000;
			pc_reg <= RST_PC;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (cmd_go) begin
						cmd_reg <= hwdata;
						pc_reg <= pc_reg + WORDS_PER_OP;
						if (op inside {op_tbl_rd_high, op_tbl_rd_low,
							op_tbl_wr_high, op_tbl_wr_low}) begin
							state_reg <= ST_TABLE;
							tcnt_reg <= 2'h1;
						end
					end
				end
				ST_TABLE: begin
					if (tcnt_reg == TBL_LAST) begin
						state_reg <= ST_IDLE;
					end else begin
						tcnt_reg <= tcnt_reg + 2'h1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// result, flags and accumulators
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_reg <= 16'h0000;
		end else if (cmd_go) begin
			res_reg <= res_n;
		end else if (tbl_done && (op_t == op_tbl_rd_high)) begin
			res_reg <= {8'h00, prog_rd[TBL_HI_LSB +: 8]};
		end else if (tbl_done && (op_t == op_tbl_rd_low)) begin
			res_reg <= prog_rd[DATA_W-1:0];
		end
	end

	// table and unlink paths leave flags_n equal to flags_reg
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_reg <= RST_FLAGS;
		end else if (wen && (da_reg == A_FLAGS)) begin
			flags_reg <= hwdata[DATA_W-1:0] & FLAG_MASK;
		end else if (cmd_go) begin
			flags_reg <= flags_n;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acca_reg <= 40'h00_0000_0000;
			accb_reg <= 40'h00_0000_0000;
		end else if (wen && (da_reg == A_ACCA_LO)) begin
			acca_reg[31:0] <= hwdata;
		end else if (wen && (da_reg == A_ACCA_HI)) begin
			acca_reg[ACC_W-1:32] <= hwdata[7:0];
		end else if (wen && (da_reg == A_ACCB_LO)) begin
			accb_reg[31:0] <= hwdata;
		end else if (wen && (da_reg == A_ACCB_HI)) begin
			accb_reg[ACC_W-1:32] <= hwdata[7:0];
		end else if (cmd_go) begin
			acca_reg <= acca_n;
			accb_reg <= accb_n;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opa_reg <= 16'h0000;
			opb_reg <= 16'h0000;
		end else if (wen && (da_reg == A_OPA)) begin
			opa_reg <= hwdata[DATA_W-1:0];
		end else if (wen && (da_reg == A_OPB)) begin
			opb_reg <= hwdata[DATA_W-1:0];
		end
	end

	// ****************************************
	// stack and frame pointers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sp_reg <= RST_SP;
			fp_reg <= RST_FP;
		end else if (wen && (da_reg == A_SP)) begin
			sp_reg <= hwdata[DATA_W-1:0];
		end else if (wen && (da_reg == A_FP)) begin
			fp_reg <= hwdata[DATA_W-1:0];
		end else if (push) begin
			sp_reg <= sp_reg + STK_STEP;
		end else if (cmd_go && (op == op_frame_unlink)) begin
			sp_reg <= fp_m2;
			fp_reg <= stk_rd;
		end
	end

	// ****************************************
	// memories
	// ****************************************
	assign pwe = tbl_done && ((op_t == op_tbl_wr_high) || (op_t == op_tbl_wr_low));
	assign pmask = (op_t == op_tbl_wr_high) ? 24'hFF0000 : 24'h00FFFF;

	cx_mem #(.W(PROG_W), .AW(PROG_AW)) u_prog (
		.clk   (hclk),
		.we    (pwe),
		.wmask (pmask),
		.waddr (opa_reg[PROG_AW-1:0]),
		.wdata ({opb_reg[7:0], opb_reg}),
		.raddr (opa_reg[PROG_AW-1:0]),
		.rdata (prog_rd)
	);

	// read port always looks at the word below the frame pointer
	cx_mem #(.W(DATA_W), .AW(STK_AW)) u_stack (
		.clk   (hclk),
		.we    (push),
		.wmask (ALL_ONES),
		.waddr (sp_reg[STK_AW:1]),
		.wdata (hwdata[DATA_W-1:0]),
		.raddr (fp_m2[STK_AW:1]),
		.rdata (stk_rd)
	);

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rd_next = 32'h0000_0000;
		if (da_reg == A_CMD) begin
			rd_next = cmd_reg;
		end else if (da_reg == A_OPA) begin
			rd_next = {16'h0000, opa_reg};
		end else if (da_reg == A_OPB) begin
			rd_next = {16'h0000, opb_reg};
		end else if (da_reg == A_RESULT) begin
			rd_next = {16'h0000, res_reg};
		end else if (da_reg == A_FLAGS) begin
			rd_next = {16'h0000, flags_reg | ((state_reg != ST_IDLE) ? BUSY_BIT : 16'h0000)};
		end else if (da_reg == A_ACCA_LO) begin
			rd_next = acca_reg[31:0];
		end else if (da_reg == A_ACCA_HI) begin
			rd_next = {24'h000000, acca_reg[ACC_W-1:32]};
		end else if (da_reg == A_ACCB_LO) begin
			rd_next = accb_reg[31:0];
		end else if (da_reg == A_ACCB_HI) begin
			rd_next = {24'h000000, accb_reg[ACC_W-1:32]};
		end else if (da_reg == A_SP) begin
			rd_next = {16'h0000, sp_reg};
		end else if (da_reg == A_FP) begin
			rd_next = {16'h0000, fp_reg};
		end else if (da_reg == A_PC) begin
			rd_next = {16'h0000, pc_reg};
		end
	end

endmodule

`default_nettype wire

// >>> rtl/cx_mem.sv
// cx_mem: single write port, registered read port memory with bit mask
// assumes one clock; contents are not reset
`default_nettype none

module cx_mem #(
	parameter int W  = 16,
	parameter int AW = 6
) (
	input  wire logic          clk,    // clock
	input  wire logic          we,     // write enable
	input  wire logic [W-1:0]  wmask,  // bits to write
	input  wire logic [AW-1:0] waddr,  // write address
	input  wire logic [W-1:0]  wdata,  // write data
	input  wire logic [AW-1:0] raddr,  // read address
	output logic      [W-1:0]  rdata   // read data, one cycle later
);
	import cx_pkg::*;

	logic [W-1:0] mem [2**AW];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
		end
		rdata <= mem[raddr];
	end

endmodule

`default_nettype wire

// >>> rtl/cx_pkg.sv
// cx_pkg: constants, offsets and enumerations of the execution datapath
// assumes a 32-bit AHB-Lite register bus and a 16-bit data path
`default_nettype none

package cx_pkg;

	localparam int BUS_W  = 32;
	localparam int DATA_W = 16;
	localparam int ACC_W  = 40;
	localparam int PROG_W = 24;
	localparam int NIB_W  = 4;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [31:0] A_CMD     = 32'h0000_0000;
	localparam logic [31:0] A_OPA     = 32'h0000_0004;
	localparam logic [31:0] A_OPB     = 32'h0000_0008;
	localparam logic [31:0] A_RESULT  = 32'h0000_000C;
	localparam logic [31:0] A_FLAGS   = 32'h0000_0010;
	localparam logic [31:0] A_ACCA_LO = 32'h0000_0014;
	localparam logic [31:0] A_ACCA_HI = 32'h0000_0018;
	localparam logic [31:0] A_ACCB_LO = 32'h0000_001C;
	localparam logic [31:0] A_ACCB_HI = 32'h0000_0020;
	localparam logic [31:0] A_SP      = 32'h0000_0024;
	localparam logic [31:0] A_FP      = 32'h0000_0028;
	localparam logic [31:0] A_PUSH    = 32'h0000_002C;
	localparam logic [31:0] A_PC      = 32'h0000_0030;

	// ****************************************
	// command word and flag fields
	// ****************************************
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_ACC_BIT = 5;
	localparam int CMD_SRC_LSB = 6;
	localparam int CMD_LIT_LSB = 16;
	localparam logic [1:0] SRC_REG   = 2'h0;
	localparam logic [1:0] SRC_LIT5  = 2'h1;
	localparam logic [1:0] SRC_LIT10 = 2'h2;

	localparam int F_CARRY       = 0;
	localparam int F_ZERO        = 1;
	localparam int F_RANGE       = 2;
	localparam int F_NEG         = 3;
	localparam int F_NIBBLE      = 4;
	localparam int F_ACCA_RNG    = 5;
	localparam int F_ACCB_RNG    = 6;
	localparam int F_ACCA_CLIP   = 7;
	localparam int F_ACCB_CLIP   = 8;
	localparam int F_EITHER_RNG  = 9;
	localparam int F_EITHER_CLIP = 10;

	localparam logic [15:0] FLAG_MASK    = 16'h07FF;
	localparam logic [15:0] BUSY_BIT     = 16'h8000;
	localparam logic [15:0] RST_FLAGS    = 16'h0000;
	localparam logic [15:0] RST_PC       = 16'h0000;
	localparam logic [15:0] RST_SP       = 16'h0000;
	localparam logic [15:0] RST_FP       = 16'h0000;
	localparam logic [15:0] ALL_ONES     = 16'hFFFF;
	localparam logic [15:0] STK_STEP     = 16'h0002;
	localparam logic [15:0] WORDS_PER_OP = 16'h0001;
	localparam logic [1:0]  TBL_LAST     = 2'h1;   // table ops take 2 cycles
	localparam int          HW_LSB       = 16;     // stored accumulator window
	localparam int          GUARD_LSB    = 31;
	localparam int          TBL_HI_LSB   = 16;
	localparam logic [39:0] RND_BIAS     = 40'h00_0000_8000;

	typedef enum logic [4:0] {
		op_rotate_right_nc, op_store_acc, op_store_acc_rnd, op_sign_extend,
		op_set_all_ones, op_acc_shift, op_left_shift1, op_left_shift_n,
		op_sub_acc, op_sub, op_sub_borrow, op_sub_rev, op_sub_rev_borrow,
		op_nibble_exch, op_byte_exch, op_tbl_rd_high, op_tbl_rd_low,
		op_tbl_wr_high, op_tbl_wr_low, op_frame_unlink, op_xor
	} cx_op_e;

	typedef enum logic {ST_IDLE, ST_TABLE} cx_state_e;

endpackage

`default_nettype wire

// >>> rtl/cx_sub.sv
// cx_sub: subtracter x - y - !ci with carry, nibble carry and overflow
// assumes combinational use inside one clock domain
`default_nettype none

module cx_sub #(
	parameter int W = 16
) (
	input  wire logic [W-1:0] x,   // minuend
	input  wire logic [W-1:0] y,   // subtrahend
	input  wire logic         ci,  // carry in, low means borrow
	output logic      [W-1:0] d,   // difference
	output logic              c,   // carry out, low means borrow
	output logic              dc,  // carry out of the low nibble
	output logic              ov   // signed range exceeded
);
	import cx_pkg::*;

	logic [W:0]     full;
	logic [NIB_W:0] low;

	assign full = {1'b0, x} + {1'b0, ~y} + {{W{1'b0}}, ci};
	assign low  = {1'b0, x[NIB_W-1:0]} + {1'b0, ~y[NIB_W-1:0]} + {{NIB_W{1'b0}}, ci};
	assign d    = full[W-1:0];
	assign c    = full[W];
	assign dc   = low[NIB_W];
	assign ov   = (x[W-1] ^ y[W-1]) & (full[W-1] ^ x[W-1]);

endmodule

`default_nettype wire

// >>> verif/cx_exec_chk.sv
// cx_exec_chk: bus timing and read-back checks on the datapath ports
// assumes one AHB-Lite master and one slave, hready = hreadyout
`default_nettype none

module cx_exec_chk (
	input wire logic                     hclk,      // clock
	input wire logic                     hresetn,   // reset, active low
	input wire logic                     hsel,      // select
	input wire logic [cx_pkg::BUS_W-1:0] haddr,     // address
	input wire logic [1:0]               htrans,    // transfer type
	input wire logic                     hwrite,    // write
	input wire logic                     hready,    // bus ready
	input wire logic [cx_pkg::BUS_W-1:0] hrdata,    // read data
	input wire logic                     hreadyout, // slave ready
	input wire logic                     hresp      // response
);
	timeunit 1ns;
	timeprecision 1ns;
	import cx_pkg::*;
	logic tk;
	assign tk = hsel & htrans[1] & hready;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_resp_okay:
	assert property (hresp == 1'b0) else $error("response not okay");
	chk_read_wait:
	assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase not two cycles");
	chk_write_fast:
	assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
	chk_low_once:
	assert property (!hreadyout |=> hreadyout) else $error("wait longer than one");
	chk_no_stray:
	assert property (!tk && hreadyout |=> hreadyout) else $error("stray wait state");
	chk_data_hold:
	assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	chk_unmap_zero:
	assert property (tk && !hwrite && haddr == 32'h00000040 |=> ##1 hrdata == 32'h0)
		else $error("unmapped read not zero");
	chk_result_high:
	assert property (tk && !hwrite && haddr == A_RESULT |=> ##1 hrdata[31:16] == 16'h0)
		else $error("result upper bits set");
	chk_flags_gap:
	assert property (tk && !hwrite && haddr == A_FLAGS |=> ##1
		hrdata[31:16] == 16'h0 && hrdata[14:11] == 4'h0) else $error("flag gap set");
endmodule

`default_nettype wire

// >>> verif/cx_exec_tb.sv
// cx_exec_tb: self-checking bench for the execution datapath
// assumes a single AHB-Lite master; hready follows hreadyout
`default_nettype none

module cx_exec_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cx_pkg::*;
	logic        hclk      = 1'b0;
	logic        hresetn   = 1'b0;
	logic [31:0] haddr     = 32'h0;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic [31:0] hwdata    = 32'h0;
	logic [31:0] q;
	wire logic [31:0] hrdata;
	wire logic        hreadyout;
	wire logic        hresp;
	int          fail_count = 0;
	int          n_tests    = 0;
	// {cmd}, {opa, opb}, {flags before, flags after, result}
	localparam logic [31:0] T [16][3] = '{
		'{32'h00000000, 32'h00010000, 32'h151D8000},
		'{32'h00000001, 32'h00000000, 32'h15151234},
		'{32'h00000002, 32'h00000000, 32'h15151235},
		'{32'h00000003, 32'h00800000, 32'h151CFF80},
		'{32'h00000004, 32'h12340000, 32'h1515FFFF},
		'{32'h00000006, 32'h40000000, 32'h111C8000},
		'{32'h00040047, 32'h01230000, 32'h1F151230},
		'{32'h00000009, 32'h00050005, 32'h00130000},
		'{32'h03FF0089, 32'h00000000, 32'h0008FC01},
		'{32'h0000000A, 32'h00050003, 32'h00110001},
		'{32'h0001004B, 32'h00020000, 32'h0008FFFF},
		'{32'h0000000C, 32'h00018000, 32'h01057FFF},
		'{32'h0000000D, 32'h12340000, 32'h1F1F1243},
		'{32'h0000000E, 32'h12340000, 32'h1F1F3412},
		'{32'h00000014, 32'hF0F0F0F0, 32'h1D170000},
		'{32'h001F0054, 32'h80000000, 32'h0008801F}
	};

	always #10 hclk = ~hclk;

	cx_exec DUT (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// waits for an edge that samples hready high
	task automatic wt;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			$display("FAIL %0t bus hang", $time);
			summarize();
		end
	endtask

	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wt();
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		q = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask

	task automatic ck(input logic [31:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		n_tests++;
		if (q !== e) begin
			fail_count++;
			$display("FAIL %0t addr %h got %h exp %h", $time, a, q, e);
		end
	endtask

	// ****************************************
	// stimulus
	// ****************************************
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (T[i]) ck(i < 5 ? A_SP + 4 * i : 32'h40, 32'h0);
		$display("test reset values done");
		wr(A_ACCA_LO, 32'h12348000);
		wr(A_ACCA_HI, 32'h0);
		for (int i = 0; i < 16; i++) begin
			wr(A_OPA, {16'h0000, T[i][1][31:16]});
			wr(A_OPB, {16'h0000, T[i][1][15:0]});
			wr(A_FLAGS, {24'h000000, T[i][2][31:24]});
			wr(A_CMD, T[i][0]);
			ck(A_RESULT, {16'h0000, T[i][2][15:0]});
			ck(A_FLAGS, {24'h000000, T[i][2][23:16]});
		end
		ck(A_PC, 32'h10);
		$display("test operation table done");
		wr(A_FLAGS, 32'h1F);
		wr(A_OPA, 32'h5);
		wr(A_OPB, 32'hABCD);
		wr(A_CMD, 32'h12);
		wr(A_OPB, 32'h1234);
		wr(A_CMD, 32'h11);
		wr(A_CMD, 32'h10);
		ck(A_RESULT, 32'hABCD);
		wr(A_CMD, 32'h0F);
		ck(A_RESULT, 32'h34);
		ck(A_FLAGS, 32'h1F);
		$display("test table access done");
		wr(A_SP, 32'h10);
		wr(A_PUSH, 32'h40);
		wr(A_FP, 32'h12);
		wr(A_CMD, 32'h13);
		ck(A_SP, 32'h10);
		ck(A_FP, 32'h40);
		ck(A_FLAGS, 32'h1F);
		ck(A_PC, 32'h15);
		$display("test frame unlink done");
		wr(A_FLAGS, 32'h0);
		wr(A_CMD, 32'h00380045);
		ck(A_ACCA_HI, 32'h12);
		ck(A_FLAGS, 32'h220);
		wr(A_CMD, 32'h28);
		ck(A_ACCB_HI, 32'hED);
		ck(A_ACCB_LO, 32'hCB800000);
		ck(A_FLAGS, 32'h260);
		wr(A_OPB, 32'h38);
		wr(A_CMD, 32'h05);
		ck(A_ACCA_LO, 32'h80000000);
		ck(A_FLAGS, 32'h6E0);
		wr(A_CMD, 32'h1F);
		ck(A_PC, 32'h19);
		$display("test accumulator ops done");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		ck(A_PC, 32'h0);
		ck(A_FLAGS, 32'h0);
		$display("test second reset done");
		summarize();
	end
endmodule

bind cx_exec cx_exec_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hrdata, .hreadyout, .hresp);

`default_nettype wire
